// [rtl/xmi_defines.vh]
// xmi_defines.vh: constants for the external data memory interface
// assumes: included by every xmi design file by bare name
`ifndef XMI_DEFINES_VH
`define XMI_DEFINES_VH

// ---------------------------------------------------------------
// register address and reset
// ---------------------------------------------------------------
`define XMI_CFG_ADDR        8'ha3
`define XMI_CFG_RESET       8'h03
`define XMI_CFG_WMASK       8'h3f

// ---------------------------------------------------------------
// ext_mem_config fields
// ---------------------------------------------------------------
`define XMI_PORT_GROUP_BIT  5
`define XMI_MUX_BIT         4
`define XMI_MODE_HI         3
`define XMI_MODE_LO         2
`define XMI_ALE_HI          1
`define XMI_ALE_LO          0

// ---------------------------------------------------------------
// memory modes
// ---------------------------------------------------------------
`define XMI_MODE_INTERNAL   2'h0
`define XMI_MODE_SPLIT      2'h1
`define XMI_MODE_BANKED     2'h2
`define XMI_MODE_EXTERNAL   2'h3

// ---------------------------------------------------------------
// address map and timing
// ---------------------------------------------------------------
`define XMI_ONCHIP_TOP      16'h2000
`define XMI_ONCHIP_MASK     16'h1fff
`define XMI_OVERHEAD        4'h4
`define XMI_TC_RESET        8'hff
`define XMI_PORT0_WR_BIT    7
`define XMI_PORT0_RD_BIT    6
`define XMI_PORT0_ALE_BIT   5

`endif

// [rtl/xmi_route.v]
// xmi_route.v: decides on-chip or off-chip and builds the bus address
// assumes: inputs are the settings captured at the start of a data move
`timescale 1ns/10ps
`include "xmi_defines.vh"

module xmi_route (
    mode,
    wide,
    pointer_addr,
    byte_addr,
    page,
    off_chip,
    bus_addr,
    drive_high,
    onchip_addr
);
    input  wire [1:0]  mode;
    input  wire        wide;
    input  wire [15:0] pointer_addr;
    input  wire [7:0]  byte_addr;
    input  wire [7:0]  page;
    output reg         off_chip;
    output reg  [15:0] bus_addr;
    output reg         drive_high;
    output wire [15:0] onchip_addr;

    wire [15:0] eff_addr;

    // 8-bit moves take the page register as upper byte for routing
    assign eff_addr    = wide ? pointer_addr : {page, byte_addr};
    assign onchip_addr = eff_addr & `XMI_ONCHIP_MASK;

    always @* begin
        bus_addr   = eff_addr;
        drive_high = 1'b1;
        off_chip   = 1'b0;
        case (mode)
            `XMI_MODE_INTERNAL: begin
                off_chip = 1'b0;
            end
            `XMI_MODE_SPLIT: begin
                off_chip   = (eff_addr >= `XMI_ONCHIP_TOP);
                drive_high = wide;
            end
            `XMI_MODE_BANKED: begin
                off_chip   = (eff_addr >= `XMI_ONCHIP_TOP);
                drive_high = 1'b1;
            end
            `XMI_MODE_EXTERNAL: begin
                off_chip   = 1'b1;
                drive_high = wide;
                bus_addr   = wide ? pointer_addr : {8'h00, byte_addr};
            end
            default: begin
                off_chip = 1'b0;
            end
        endcase
    end
endmodule // xmi_route

// [rtl/xmi_timer.v]
// xmi_timer.v: loadable down counter that times each bus phase
// assumes: single clock, enable freezes the count
`timescale 1ns/10ps
`include "xmi_defines.vh"

module xmi_timer (
    clock,
    rst_n,
    clk_en,
    load,
    load_value,
    done
);
    input  wire       clock;
    input  wire       rst_n;
    input  wire       clk_en;
    input  wire       load;
    input  wire [3:0] load_value;
    output wire       done;

    reg [3:0] count;

    assign done = (count == 4'h0);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 4'h0;
        end else if (clk_en) begin
            if (load) begin
                count <= load_value;
            end else if (count != 4'h0) begin
                count <= count - 4'h1;
            end
        end
    end
endmodule // xmi_timer

// [rtl/xmi_core.v]
// xmi_core.v: external data memory interface, config register and bus sequencer
// assumes: cpu requests a data move with move_req and waits for move_done;
// the register port is the documented special function register bus
//
// Contract
// - port group select: 0 puts bus on lower ports, 1 on upper ports
// - multiplex select: 0 shared address/data pins, 1 separate pins
// - mode 00: all moves on-chip, addresses alias into on-chip space
// - mode 01 splits the map between on-chip and off-chip
// - banked mode: addresses below 8k go on-chip
// - banked mode: addresses at or above 8k go off-chip
// - banked 8-bit move: page register high byte, byte pointer low byte
// - banked mode drives all sixteen address lines off-chip
// - banked 16-bit move routed by wide pointer, sixteen lines driven
// - mode 11: all moves off-chip, on-chip ram unreachable
// - external 8-bit move ignores page, upper address undriven
// - external 8-bit move low address from byte pointer
// - external 16-bit move drives full wide pointer address
// - latch pulse field sets high and low widths: 1, 2, 3, 4 cycles
// - setup, hold, strobe and latch widths programmable in whole cycles
// - off-chip move lasts timing parameters plus four cycles
// - non-multiplexed shortest off-chip move is five cycles
// - multiplexed shortest off-chip move is seven cycles
// - setup and hold reset to their longest settings
`timescale 1ns/10ps
`include "xmi_defines.vh"

module xmi_core (
    clock,
    rst_n,
    clk_en,
    sfr_addr,
    sfr_wdata,
    sfr_write,
    sfr_rdata,
    upper_address_page,
    bus_timing_control,
    move_req,
    move_write,
    move_wide,
    move_sel_b,
    wide_data_pointer,
    byte_pointer_a,
    byte_pointer_b,
    move_wdata,
    move_done,
    move_rdata,
    ram_en,
    ram_we,
    ram_addr,
    ram_wdata,
    ram_rdata,
    bus_upper_ports,
    bus_multiplexed,
    bus_addr,
    bus_addr_hi_en_n,
    bus_addr_lo_en_n,
    bus_data_out,
    bus_data_en_n,
    bus_data_in,
    bus_latch,
    bus_rd_n,
    bus_wr_n,
    port0_ctrl_en
);
    input  wire        clock;
    input  wire        rst_n;
    input  wire        clk_en;
    input  wire [7:0]  sfr_addr;
    input  wire [7:0]  sfr_wdata;
    input  wire        sfr_write;
    output reg  [7:0]  sfr_rdata;
    input  wire [7:0]  upper_address_page;
    input  wire [7:0]  bus_timing_control;
    input  wire        move_req;
    input  wire        move_write;
    input  wire        move_wide;
    input  wire        move_sel_b;
    input  wire [15:0] wide_data_pointer;
    input  wire [7:0]  byte_pointer_a;
    input  wire [7:0]  byte_pointer_b;
    input  wire [7:0]  move_wdata;
    output reg         move_done;
    output reg  [7:0]  move_rdata;
    output reg         ram_en;
    output reg         ram_we;
    output reg  [12:0] ram_addr;
    output reg  [7:0]  ram_wdata;
    input  wire [7:0]  ram_rdata;
    output reg         bus_upper_ports;
    output reg         bus_multiplexed;
    output reg  [15:0] bus_addr;
    output reg         bus_addr_hi_en_n;
    output reg         bus_addr_lo_en_n;
    output reg  [7:0]  bus_data_out;
    output reg         bus_data_en_n;
    input  wire [7:0]  bus_data_in;
    output reg         bus_latch;
    output reg         bus_rd_n;
    output reg         bus_wr_n;
    output reg         port0_ctrl_en;

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    localparam ST_IDLE   = 3'h0;
    localparam ST_ALE_HI = 3'h1;
    localparam ST_ALE_LO = 3'h2;
    localparam ST_SETUP  = 3'h3;
    localparam ST_STROBE = 3'h4;
    localparam ST_HOLD   = 3'h5;
    localparam ST_RAM    = 3'h7;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    reg sync_a;
    reg rst_q_n;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_a  <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            sync_a  <= 1'b1;
            rst_q_n <= sync_a;
        end
    end

    // ---------------------------------------------------------------
    // ext_mem_config register
    // ---------------------------------------------------------------
    reg [7:0] ext_mem_config;
    wire      cfg_hit = (sfr_addr == `XMI_CFG_ADDR);

    always @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ext_mem_config <= `XMI_CFG_RESET;
            sfr_rdata      <= 8'h00;
        end else if (clk_en) begin
            if (sfr_write && cfg_hit) begin
                ext_mem_config <= sfr_wdata & `XMI_CFG_WMASK;
            end
            sfr_rdata <= cfg_hit ? ext_mem_config : 8'h00;
        end
    end

    // field widths as cycle counts; code n gives n+1 cycles
    function [3:0] field_cycles;
        input [1:0] code;
        begin
            field_cycles = {2'h0, code} + 4'h1;
        end
    endfunction

    // ---------------------------------------------------------------
    // per-move snapshot: later writes wait for the next move
    // ---------------------------------------------------------------
    reg [2:0]  state;
    reg [1:0]  snap_mode;
    reg        snap_mux;
    reg [1:0]  snap_ale;
    reg [7:0]  snap_tc;
    reg        snap_write;
    reg        snap_wide;
    reg [15:0] snap_ptr;
    reg [7:0]  snap_byte;
    reg [7:0]  snap_page;
    reg [7:0]  snap_data;
    reg        routed;

    wire        rt_off;
    wire [15:0] rt_addr;
    wire        rt_drive_hi;
    wire [15:0] rt_onchip;

    xmi_route u_route (
        .mode         (snap_mode),
        .wide         (snap_wide),
        .pointer_addr (snap_ptr),
        .byte_addr    (snap_byte),
        .page         (snap_page),
        .off_chip     (rt_off),
        .bus_addr     (rt_addr),
        .drive_high   (rt_drive_hi),
        .onchip_addr  (rt_onchip)
    );

    // timing control: [7:6] setup, [5:4] strobe, [3:2] hold, [1:0] spare
    reg        tmr_load;
    reg [3:0]  tmr_value;
    wire       tmr_done;

    xmi_timer u_timer (
        .clock      (clock),
        .rst_n      (rst_q_n),
        .clk_en     (clk_en),
        .load       (tmr_load),
        .load_value (tmr_value),
        .done       (tmr_done)
    );

    // counter is loaded with n-1 so a phase lasts exactly n cycles
    reg       phase_end;
    reg [2:0] next_state;
    always @* begin
        phase_end  = tmr_done;
        next_state = state;
        tmr_load   = 1'b0;
        tmr_value  = 4'h0;
        case (state)
            ST_IDLE: begin
                // first phase is loaded while the route is decided, so its width counts in full
                if (routed) begin
                    tmr_load  = 1'b1;
                    tmr_value = field_cycles(snap_mux ? snap_tc[7:6] : snap_ale) - 4'h1;
                end
            end
            ST_ALE_HI: begin
                if (phase_end) begin
                    next_state = ST_ALE_LO;
                    tmr_load   = 1'b1;
                    tmr_value  = field_cycles(snap_ale) - 4'h1;
                end
            end
            ST_ALE_LO: begin
                if (phase_end) begin
                    next_state = ST_SETUP;
                    tmr_load   = 1'b1;
                    tmr_value  = field_cycles(snap_tc[7:6]) - 4'h1;
                end
            end
            ST_SETUP: begin
                if (phase_end) begin
                    next_state = ST_STROBE;
                    tmr_load   = 1'b1;
                    tmr_value  = field_cycles(snap_tc[5:4]) - 4'h1;
                end
            end
            ST_STROBE: begin
                if (phase_end) begin
                    next_state = ST_HOLD;
                    tmr_load   = 1'b1;
                    tmr_value  = field_cycles(snap_tc[3:2]) - 4'h1;
                end
            end
            ST_HOLD: begin
                // route cycle, first setup and hold cycles and the done cycle are the fixed four
                if (phase_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RAM: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // sequencer and bus pins
    // ---------------------------------------------------------------
    always @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            state            <= ST_IDLE;
            routed           <= 1'b0;
            snap_mode        <= 2'h0;
            snap_mux         <= 1'b0;
            snap_ale         <= 2'h0;
            snap_tc          <= `XMI_TC_RESET;
            snap_write       <= 1'b0;
            snap_wide        <= 1'b0;
            snap_ptr         <= 16'h0000;
            snap_byte        <= 8'h00;
            snap_page        <= 8'h00;
            snap_data        <= 8'h00;
            move_done        <= 1'b0;
            move_rdata       <= 8'h00;
            ram_en           <= 1'b0;
            ram_we           <= 1'b0;
            ram_addr         <= 13'h0000;
            ram_wdata        <= 8'h00;
            bus_upper_ports  <= 1'b0;
            bus_multiplexed  <= 1'b1;
            bus_addr         <= 16'h0000;
            bus_addr_hi_en_n <= 1'b1;
            bus_addr_lo_en_n <= 1'b1;
            bus_data_out     <= 8'h00;
            bus_data_en_n    <= 1'b1;
            bus_latch        <= 1'b0;
            bus_rd_n         <= 1'b1;
            bus_wr_n         <= 1'b1;
            port0_ctrl_en    <= 1'b0;
        end else if (clk_en) begin
            move_done <= 1'b0;
            ram_en    <= 1'b0;
            ram_we    <= 1'b0;
            routed    <= 1'b0;
            if (state == ST_IDLE && move_req && !routed) begin
                // settings sampled here hold for the whole move
                snap_mode       <= ext_mem_config[`XMI_MODE_HI:`XMI_MODE_LO];
                snap_mux        <= ext_mem_config[`XMI_MUX_BIT];
                snap_ale        <= ext_mem_config[`XMI_ALE_HI:`XMI_ALE_LO];
                snap_tc         <= bus_timing_control;
                snap_write      <= move_write;
                snap_wide       <= move_wide;
                snap_ptr        <= wide_data_pointer;
                snap_byte       <= move_sel_b ? byte_pointer_b : byte_pointer_a;
                snap_page       <= upper_address_page;
                snap_data       <= move_wdata;
                bus_upper_ports <= ext_mem_config[`XMI_PORT_GROUP_BIT];
                bus_multiplexed <= !ext_mem_config[`XMI_MUX_BIT];
                port0_ctrl_en   <= !ext_mem_config[`XMI_PORT_GROUP_BIT];
                routed          <= 1'b1;
            end else if (routed) begin
                // route decision taken one cycle after capture
                if (!rt_off) begin
                    state     <= ST_RAM;
                    ram_en    <= 1'b1;
                    ram_we    <= snap_write;
                    ram_addr  <= rt_onchip[12:0];
                    ram_wdata <= snap_data;
                end else begin
                    state            <= snap_mux ? ST_SETUP : ST_ALE_HI;
                    bus_addr         <= rt_addr;
                    bus_addr_lo_en_n <= 1'b0;
                    bus_addr_hi_en_n <= !rt_drive_hi;
                    bus_latch        <= !snap_mux;
                end
            end else begin
                state <= next_state;
                if (state == ST_ALE_HI && phase_end) begin
                    bus_latch <= 1'b0;
                end
                if (next_state == ST_STROBE && state != ST_STROBE) begin
                    bus_rd_n      <= snap_write;
                    bus_wr_n      <= !snap_write;
                    bus_data_out  <= snap_data;
                    bus_data_en_n <= !snap_write;
                end
                if (state == ST_STROBE && phase_end) begin
                    bus_rd_n <= 1'b1;
                    bus_wr_n <= 1'b1;
                    if (!snap_write) begin
                        move_rdata <= bus_data_in;
                    end
                end
                if (state == ST_HOLD && phase_end) begin
                    move_done        <= 1'b1;
                    bus_addr_hi_en_n <= 1'b1;
                    bus_addr_lo_en_n <= 1'b1;
                    bus_data_en_n    <= 1'b1;
                end
                if (state == ST_RAM) begin
                    move_done <= 1'b1;
                    if (!snap_write) begin
                        move_rdata <= ram_rdata;
                    end
                end
            end
        end
    end
endmodule // xmi_core

// [verification/xmi_core_chk.sv]
// xmi_core_chk.sv: concurrent checks on the ports of xmi_core
// assumes: bound into xmi_core, clk_en held high by the bench
`timescale 1ns/10ps

module xmi_core_chk (
    input wire clock,
    input wire rst_n,
    input wire move_req,
    input wire move_done,
    input wire ram_en,
    input wire bus_upper_ports,
    input wire bus_multiplexed,
    input wire bus_addr_lo_en_n,
    input wire bus_latch,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire port0_ctrl_en
);
    reg       busy;
    reg [5:0] cnt;
    reg       saw_ram;
    reg       saw_stb;

    // ------------------------------------------------------------
    // move tracking: cnt counts edges since the take
    // ------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            cnt     <= 6'h00;
            saw_ram <= 1'b0;
            saw_stb <= 1'b0;
        end else if (move_req && (!busy || move_done)) begin
            busy    <= 1'b1;
            cnt     <= 6'h01;
            saw_ram <= 1'b0;
            saw_stb <= 1'b0;
        end else if (busy) begin
            busy    <= !move_done;
            cnt     <= cnt + 6'h01;
            saw_ram <= saw_ram | ram_en;
            saw_stb <= saw_stb | !bus_rd_n | !bus_wr_n;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_strobe;
        !bus_rd_n || !bus_wr_n;
    endsequence
    sequence s_end_on;
        move_done && saw_ram;
    endsequence
    sequence s_end_off;
        move_done && saw_stb;
    endsequence

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_done_single: assert property (move_done |=> !move_done) else $error("done held");
    chk_move_bound: assert property (busy |-> cnt < 6'h28) else $error("move too long");
    chk_onchip_time: assert property (s_end_on |-> cnt == 6'h03) else $error("on-chip time");
    chk_nonmux_min: assert property (s_end_off |-> bus_multiplexed || cnt >= 6'h05) else $error("short move");
    chk_mux_min: assert property (s_end_off |-> !bus_multiplexed || cnt >= 6'h07) else $error("short mux move");
    chk_strobe_excl: assert property (s_strobe |-> bus_rd_n || bus_wr_n) else $error("both strobes");
    chk_strobe_addr: assert property (s_strobe |-> busy && !bus_addr_lo_en_n) else $error("address off");
    chk_latch_mux: assert property (bus_latch |-> bus_multiplexed) else $error("latch unmuxed");
    chk_port0_lower: assert property (port0_ctrl_en |-> !bus_upper_ports) else $error("port0 owned");
    chk_settings_hold: assert property (busy && cnt > 6'h01 && !move_done |->
        $stable(bus_multiplexed) && $stable(bus_upper_ports)) else $error("settings moved");
endmodule // xmi_core_chk

bind xmi_core xmi_core_chk xmi_core_chk_inst (
    .clock(clock), .rst_n(rst_n), .move_req(move_req), .move_done(move_done), .ram_en(ram_en),
    .bus_upper_ports(bus_upper_ports), .bus_multiplexed(bus_multiplexed), .bus_addr_lo_en_n(bus_addr_lo_en_n),
    .bus_latch(bus_latch), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .port0_ctrl_en(port0_ctrl_en)
);

// [verification/xmi_ext_mem.sv]
// xmi_ext_mem.sv: behavioural asynchronous memory on the off-chip bus
// assumes: active-low strobes, low address latched while the latch is high
`timescale 1ns/10ps

module xmi_ext_mem (
    input  wire        clock,
    input  wire [15:0] bus_addr,
    input  wire        bus_addr_hi_en_n,
    input  wire        bus_multiplexed,
    input  wire        bus_latch,
    input  wire [7:0]  bus_data_out,
    input  wire        bus_data_en_n,
    input  wire        bus_rd_n,
    input  wire        bus_wr_n,
    output wire [7:0]  bus_data_in
);
    reg  [7:0]  mem [0:65535];
    reg  [7:0]  lo_q;
    reg  [7:0]  last;
    wire [15:0] addr;

    // undriven upper lines read as zero, standing in for the port latch
    assign addr = {bus_addr_hi_en_n ? 8'h00 : bus_addr[15:8], bus_multiplexed ? lo_q : bus_addr[7:0]};
    always @(posedge clock) begin
        if (bus_latch)
            lo_q <= bus_addr[7:0];
        // data not driven during the strobe is stored as garbage
        if (!bus_wr_n)
            mem[addr] <= bus_data_en_n ? ~last : bus_data_out;
        if (!bus_rd_n)
            last <= mem[addr];
    end
    // released data lines show the inverse, never a stale copy
    assign bus_data_in = bus_rd_n ? ~last : mem[addr];
endmodule // xmi_ext_mem

// [verification/xmi_core_test.sv]
// xmi_core_test.sv: self-checking bench for xmi_core
// assumes: design, partner memory and checker are compiled before it
`timescale 1ns/10ps

module xmi_core_test;
    reg         clock, rst_n, sfr_write, move_req, move_write, move_wide, move_sel_b, hi_drv;
    reg  [7:0]  sfr_addr, sfr_wdata, upper_address_page, bus_timing_control;
    reg  [7:0]  byte_pointer_a, byte_pointer_b, move_wdata, cfg, d;
    reg  [15:0] wide_data_pointer;
    reg  [31:0] r, r2;
    reg  [17:0] e;
    reg  [5:0]  cyc, stb, lat;
    reg  [7:0]  ram [0:8191];
    wire [7:0]  sfr_rdata, move_rdata, ram_wdata, ram_rdata, bus_data_out, bus_data_in;
    wire [12:0] ram_addr;
    wire [15:0] bus_addr;
    wire        move_done, ram_en, ram_we, bus_upper_ports, bus_multiplexed, bus_addr_hi_en_n;
    wire        bus_addr_lo_en_n, bus_data_en_n, bus_latch, bus_rd_n, bus_wr_n, port0_ctrl_en;
    integer     num_errors, n_compared, seed, i;

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // every bench signal carries the name of the port it meets
    xmi_core xmi_core_inst (.clk_en(1'b1), .*);
    xmi_ext_mem xmi_ext_mem_inst (.*);

    // ------------------------------------------------------------
    // on-chip ram and move monitor
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (ram_en && ram_we)
            ram[ram_addr] <= ram_wdata;
        if (move_req) begin
            cyc <= 6'h01;
            stb <= 6'h00;
            lat <= 6'h00;
            hi_drv <= 1'b0;
        end else begin
            cyc <= cyc + 6'h01;
            if (!bus_rd_n || !bus_wr_n) begin
                stb <= stb + 6'h01;
                hi_drv <= hi_drv | !bus_addr_hi_en_n;
            end
            if (bus_latch)
                lat <= lat + 6'h01;
        end
    end
    // read data stands only while the enable is high
    assign ram_rdata = ram_en ? ram[ram_addr] : ~ram[ram_addr];

    // ------------------------------------------------------------
    // expectations, tasks and verdict
    // ------------------------------------------------------------
    function [17:0] route(input [1:0] m, input wd, input [15:0] dp, input [7:0] pg, input [7:0] p);
        reg [15:0] a;
        begin
            a = wd ? dp : {pg, p};
            if (m == 2'h0 || (m != 2'h3 && a < 16'h2000))
                route = {5'h00, a[12:0]};
            else if (wd || m == 2'h2)
                route = {2'b11, a};
            else
                route = {10'h200, p};
        end
    endfunction

    // edges from take to done: setup + strobe (at least 1) + hold + 4, plus latch high and low
    function integer mv_len(input [7:0] tc, input [7:0] c);
        mv_len = tc[7:6] + tc[5:4] + 1 + tc[3:2] + 4 + (c[4] ? 0 : 2 * (c[1:0] + 1));
    endfunction

    task check(input [95:0] what, input [15:0] exp, input [15:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task sfr_wr(input [7:0] a, input [7:0] v);
        begin
            sfr_addr = a;
            sfr_wdata = v;
            sfr_write = 1'b1;
            @(negedge clock);
            sfr_write = 1'b0;
        end
    endtask

    task sfr_rd(input [7:0] a, input [7:0] exp);
        begin
            sfr_addr = a;
            @(negedge clock);
            check("sfr read", exp, sfr_rdata);
        end
    endtask

    // mid, when not zero, is written to the config while the move runs
    task move(input wr, input [7:0] v, input [7:0] mid);
        integer n;
        begin
            move_write = wr;
            move_wdata = v;
            move_req = 1'b1;
            @(negedge clock);
            move_req = 1'b0;
            if (mid != 8'h00)
                sfr_wr(8'ha3, mid);
            n = 0;
            while (move_done !== 1'b1 && n < 60) begin
                @(negedge clock);
                n = n + 1;
            end
            check("move done", 1'b1, move_done);
        end
    endtask

    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial begin
        #(25 * 20000);
        num_errors = num_errors + 1;
        test_done;
    end

    initial begin
        seed = 32'h07e0dbd3;
        num_errors = 0;
        n_compared = 0;
        {rst_n, sfr_write, move_req, move_write, move_wide, move_sel_b} = 6'h00;
        {sfr_addr, sfr_wdata, upper_address_page, bus_timing_control} = 32'h0;
        {byte_pointer_a, byte_pointer_b, move_wdata, wide_data_pointer} = 40'h0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        sfr_rd(8'ha3, 8'h03);
        sfr_rd(8'ha4, 8'h00);
        // every mode, mux and port group, pointers on both sides of 8k
        for (i = 0; i < 48; i = i + 1) begin
            r = $random(seed);
            r2 = $random(seed);
            cfg = {r[7:6], i[0], i[1], i[3:2], r[1:0]};
            sfr_wr(8'ha3, cfg);
            sfr_rd(8'ha3, cfg & 8'h3f);
            bus_timing_control = r[15:8];
            move_wide = r[16];
            move_sel_b = r[17];
            wide_data_pointer = i[4] ? r[31:16] : (i[5] ? 16'h2000 : 16'h1fff);
            upper_address_page = i[4] ? r2[15:8] : (i[5] ? 8'h20 : 8'h1f);
            byte_pointer_a = r2[7:0];
            byte_pointer_b = r2[23:16];
            d = r2[31:24];
            e = route(cfg[3:2], move_wide, wide_data_pointer, upper_address_page,
                      move_sel_b ? byte_pointer_b : byte_pointer_a);
            move(1'b1, d, 8'h00);
            check("upper ports", cfg[5], bus_upper_ports);
            check("multiplexed", !cfg[4], bus_multiplexed);
            if (e[17]) begin
                check("offchip mem", d, xmi_ext_mem_inst.mem[e[15:0]]);
                check("strobe", bus_timing_control[5:4] + 16'h1, stb);
                check("latch", cfg[4] ? 16'h0 : cfg[1:0] + 16'h1, lat);
                check("hi driven", e[16], hi_drv);
                check("move length", mv_len(bus_timing_control, cfg), cyc);
            end else begin
                check("onchip ram", d, ram[e[12:0]]);
                check("onchip time", 16'h3, cyc);
                check("no strobe", 16'h0, stb);
            end
            move(1'b0, 8'h00, i[3] ? (cfg ^ 8'h3c) : 8'h00);
            check("read data", d, move_rdata);
        end
        test_done;
    end
endmodule // xmi_core_test
